// >>> fbalu_pkg.sv
// Shared constants for the four-bit function generator
package fbalu_pkg;
    // Datapath width of one slice
    localparam int FBALU_W = 4;
    // Select codes used by the assertions and the bench
    localparam logic [3:0] FBALU_SEL_PASS = 4'h0;
    localparam logic [3:0] FBALU_SEL_SUB = 4'h6;
    localparam logic [3:0] FBALU_SEL_ADD = 4'h9;
    localparam logic [3:0] FBALU_SEL_DBL = 4'hC;
    // Reset values of the registered outputs
    localparam logic [3:0] FBALU_RST_RESULT = 4'h0;
    localparam logic FBALU_RST_CARRY = 1'b1;
    localparam logic FBALU_RST_PROP = 1'b1;
    localparam logic FBALU_RST_GEN = 1'b1;
    localparam logic FBALU_RST_EQ_OE = 1'b1;
endpackage

// >>> fbalu_if.sv
// Signal bundle between the registered shell and the function core
interface fbalu_if;
    import fbalu_pkg::*;
    logic [FBALU_W-1:0] opa;
    logic [FBALU_W-1:0] opb;
    logic [3:0] sel;
    logic mode;
    logic cin_n;
    logic [FBALU_W-1:0] res;
    logic cout_n;
    logic prop_n;
    logic gen_n;
    logic equal;
    modport core (
        input opa, opb, sel, mode, cin_n,
        output res, cout_n, prop_n, gen_n, equal
    );
    modport user (
        output opa, opb, sel, mode, cin_n,
        input res, cout_n, prop_n, gen_n, equal
    );
endinterface

// >>> fbalu_core.sv
// Stateless function core: per-bit terms, carry chain, cascade outputs
module fbalu_core
    import fbalu_pkg::*;
(
    // Operands, selects and results
    fbalu_if.core io
);
    logic [FBALU_W-1:0] nor_t;
    logic [FBALU_W-1:0] nand_t;
    logic [FBALU_W-1:0] prop;
    logic [FBALU_W-1:0] gen;
    logic [FBALU_W:0] carry;

    // Carry into bit 0 is the inverted pin; pin high means no carry
    assign carry[0] = ~io.cin_n;

    // Per-bit select gating, carry ripple and result bit
    genvar i;
    generate
        for (i = 0; i < FBALU_W; i++) begin : g_bit
            // Select lines pick which operand terms feed each bit
            assign nor_t[i] = ~(io.opa[i] | (io.opb[i] & io.sel[0])
                | (~io.opb[i] & io.sel[1]));
            assign nand_t[i] = ~((io.opa[i] & ~io.opb[i] & io.sel[2])
                | (io.opa[i] & io.opb[i] & io.sel[3]));
            assign prop[i] = ~nor_t[i];
            assign gen[i] = ~nand_t[i];
            // Ripple carry toward the top bit
            assign carry[i+1] = gen[i] | (prop[i] & carry[i]);
            // Mode high masks the carry, leaving a pure bitwise function
            assign io.res[i] = ~((nor_t[i] ^ nand_t[i])
                ^ (~io.mode & ~carry[i]));
        end
    endgenerate

    // Ones-complement subtrahend comes from the select gating above
    assign io.cout_n = ~carry[FBALU_W];
    // Group terms for an outside look-ahead unit, low active
    assign io.prop_n = ~(&prop);
    assign io.gen_n = ~(gen[3] | (prop[3] & gen[2])
        | (prop[3] & prop[2] & gen[1])
        | (prop[3] & prop[2] & prop[1] & gen[0]));
    // Equality is decoded from the result bits only
    assign io.equal = &io.res;
endmodule

// >>> fbalu_top.sv
// Four-bit arithmetic and logic function generator with registered outputs
// How it works
// - Two 4-bit words give a 4-bit result; sixteen arithmetic operations.
// - Mode low lets carries ripple between bits, giving arithmetic.
// - Mode high blocks carries, giving sixteen bitwise logic functions.
// - Group propagate and generate cover four bits for look-ahead.
// - Ripple carry enters bit 0 and leaves from bit 3.
// - Subtract adds the complemented subtrahend: A-B-1, forced carry gives A-B.
// - Equality output is high when all result bits are high.
// - Equality output is open-collector so several can be wire-ANDed.
// - In subtract, carry-in and carry-out pair give relative magnitude.
// - Same pins serve active-low data; cascade outputs read inverted.
// - Active-high and active-low operation sets come from one mapping.
// - Adding an operand to itself shifts each bit one place up.
module fbalu_top
    import fbalu_pkg::*;
(
    // Clock, enable and reset
    input wire logic clk,
    input wire logic clk_en,
    input wire logic sys_rst,
    // Operands
    input wire logic [FBALU_W-1:0] operand_a,
    input wire logic [FBALU_W-1:0] operand_b,
    // Function selects, mode and carry pin (low means carry)
    input wire logic func_select_bit0,
    input wire logic func_select_bit1,
    input wire logic func_select_bit2,
    input wire logic func_select_bit3,
    input wire logic mode_ctrl,
    input wire logic carry_input,
    // Result bits
    output logic result_bit0,
    output logic result_bit1,
    output logic result_bit2,
    output logic result_bit3,
    // Carry and look-ahead outputs, low active
    output logic carry_output,
    output logic group_prop_n,
    output logic group_gen_n,
    // Open-collector equality pin: output level and enable
    output logic equal_out,
    output logic equal_oe
);
    fbalu_if link ();

    logic [FBALU_W-1:0] result_r;
    logic [FBALU_W-1:0] result_nxt;
    logic carry_r;
    logic carry_nxt;
    logic prop_r;
    logic prop_nxt;
    logic gen_r;
    logic gen_nxt;
    logic eq_oe_r;
    logic eq_oe_nxt;

    // Drive the core straight from the pins
    assign link.opa = operand_a;
    assign link.opb = operand_b;
    assign link.sel = {func_select_bit3, func_select_bit2,
        func_select_bit1, func_select_bit0};
    assign link.mode = mode_ctrl;
    assign link.cin_n = carry_input;

    // Pure combinational core; the only state is the output stage
    fbalu_core u_core (
        .io(link.core)
    );

    // Next output values; a low enable holds the previous ones
    always_comb begin
        result_nxt = result_r;
        carry_nxt = carry_r;
        prop_nxt = prop_r;
        gen_nxt = gen_r;
        eq_oe_nxt = eq_oe_r;
        if (sys_rst) begin
            result_nxt = FBALU_RST_RESULT;
            carry_nxt = FBALU_RST_CARRY;
            prop_nxt = FBALU_RST_PROP;
            gen_nxt = FBALU_RST_GEN;
            eq_oe_nxt = FBALU_RST_EQ_OE;
        end else if (clk_en) begin
            result_nxt = link.res;
            carry_nxt = link.cout_n;
            prop_nxt = link.prop_n;
            gen_nxt = link.gen_n;
            // Only ever pull low; high is left to the pull-up
            eq_oe_nxt = ~link.equal;
        end
    end

    // Output stage registers
    always_ff @(posedge clk) begin
        result_r <= result_nxt;
        carry_r <= carry_nxt;
        prop_r <= prop_nxt;
        gen_r <= gen_nxt;
        eq_oe_r <= eq_oe_nxt;
    end

    // Every output but the constant equal_out comes straight from a flip-flop
    assign result_bit0 = result_r[0];
    assign result_bit1 = result_r[1];
    assign result_bit2 = result_r[2];
    assign result_bit3 = result_r[3];
    assign carry_output = carry_r;
    assign group_prop_n = prop_r;
    assign group_gen_n = gen_r;
    // Open-collector: level is always low, enable decides
    assign equal_out = 1'b0;
    assign equal_oe = eq_oe_r;

    // Helper terms for the checks below
    logic [3:0] sel_w;
    logic [4:0] sum_w;
    logic [3:0] res_w;
    assign sel_w = link.sel;
    assign sum_w = {1'b0, operand_a} + {1'b0, operand_b};
    assign res_w = {result_bit3, result_bit2, result_bit1, result_bit0};

    // Plain add with the carry pin released
    property p_add;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == FBALU_SEL_ADD && carry_input
        |=> res_w == $past(sum_w[3:0]);
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");

    // A live carry on the transfer code must add one
    property p_incr;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == FBALU_SEL_PASS && !carry_input
        |=> res_w == $past(operand_a) + 4'h1;
    endproperty
    a_incr: assert property (p_incr) else $error("carry not used");

    // Logic mode on the subtract code gives exclusive-OR
    property p_xor;
        @(posedge clk) disable iff (sys_rst)
        clk_en && mode_ctrl && sel_w == FBALU_SEL_SUB
        |=> res_w == ($past(operand_a) ^ $past(operand_b));
    endproperty
    a_xor: assert property (p_xor) else $error("logic xor wrong");

    // Group generate must agree with the carry out of a plain add, propagate with A OR B
    property p_gen;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == FBALU_SEL_ADD
        |=> group_gen_n == !$past(sum_w[4]) && group_prop_n ==
            !(&($past(operand_a) | $past(operand_b)));
    endproperty
    a_gen: assert property (p_gen) else $error("cascade wrong");

    // Ripple out is low active, so overflow pulls it low
    property p_cout;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == FBALU_SEL_ADD && !carry_input
        |=> carry_output == !($past(sum_w) + 5'h01 > 5'h0F);
    endproperty
    a_cout: assert property (p_cout) else $error("ripple out wrong");

    // Without the forced carry the difference is one short
    property p_sub;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == FBALU_SEL_SUB && carry_input
        |=> res_w == $past(operand_a) - $past(operand_b) - 4'h1;
    endproperty
    a_sub: assert property (p_sub) else $error("subtract wrong");

    // Enable high pulls the wire low, meaning not equal
    property p_equal;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == FBALU_SEL_SUB && carry_input
        |=> equal_oe == ($past(operand_a) != $past(operand_b));
    endproperty
    a_equal: assert property (p_equal) else $error("equal wrong");

    // Carry pin high on both ends reads as A not above B
    property p_mag;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == FBALU_SEL_SUB && carry_input
        |=> carry_output == ($past(operand_a) <= $past(operand_b));
    endproperty
    a_mag: assert property (p_mag) else $error("magnitude wrong");

    // Doubling moves every bit one place up
    property p_dbl;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == FBALU_SEL_DBL && carry_input
        |=> res_w == {$past(operand_a[2:0]), 1'b0};
    endproperty
    a_dbl: assert property (p_dbl) else $error("shift wrong");

    // Enable low freezes result and ripple out
    property p_hold;
        @(posedge clk) disable iff (sys_rst)
        !clk_en ##1 !sys_rst |-> $stable(res_w) && $stable(carry_output);
    endproperty
    a_hold: assert property (p_hold) else $error("hold broken");

    // Top select with no carry counts down by one
    property p_dec;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == 4'hF && carry_input
        |=> res_w == $past(operand_a) - 4'h1;
    endproperty
    a_dec: assert property (p_dec) else $error("dec wrong");

    // Same select with a carry passes A straight through
    property p_pass;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == 4'hF && !carry_input
        |=> res_w == $past(operand_a);
    endproperty
    a_pass: assert property (p_pass) else $error("pass wrong");

    // Constant minus one when no carry enters
    property p_minus1;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == 4'h3 && carry_input
        |=> res_w == 4'hF;
    endproperty
    a_minus1: assert property (p_minus1) else $error("m1 wrong");

    // The carry ripples through all bits to give zero
    property p_zero;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == 4'h3 && !carry_input
        |=> res_w == 4'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("zero wrong");

    // Logic constant zero, whatever the carry pin says
    property p_lzero;
        @(posedge clk) disable iff (sys_rst)
        clk_en && mode_ctrl && sel_w == 4'h3
        |=> res_w == 4'h0;
    endproperty
    a_lzero: assert property (p_lzero) else $error("lzero bad");

    // Logic constant one
    property p_lone;
        @(posedge clk) disable iff (sys_rst)
        clk_en && mode_ctrl && sel_w == 4'hC
        |=> res_w == 4'hF;
    endproperty
    a_lone: assert property (p_lone) else $error("lone bad");

    // Logic inversion of A
    property p_nota;
        @(posedge clk) disable iff (sys_rst)
        clk_en && mode_ctrl && sel_w == 4'h0
        |=> res_w == ~$past(operand_a);
    endproperty
    a_nota: assert property (p_nota) else $error("nota bad");

    // Logic AND
    property p_and;
        @(posedge clk) disable iff (sys_rst)
        clk_en && mode_ctrl && sel_w == 4'hB
        |=> res_w == ($past(operand_a) & $past(operand_b));
    endproperty
    a_and: assert property (p_and) else $error("and bad");

    // Logic OR
    property p_or;
        @(posedge clk) disable iff (sys_rst)
        clk_en && mode_ctrl && sel_w == 4'hE
        |=> res_w == ($past(operand_a) | $past(operand_b));
    endproperty
    a_or: assert property (p_or) else $error("or bad");

    // Logic NOR
    property p_nor;
        @(posedge clk) disable iff (sys_rst)
        clk_en && mode_ctrl && sel_w == 4'h1
        |=> res_w == ~($past(operand_a) | $past(operand_b));
    endproperty
    a_nor: assert property (p_nor) else $error("nor bad");

    // Equal words in subtract propagate across the whole group
    property p_peq;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == FBALU_SEL_SUB
        && operand_a == operand_b
        |=> !group_prop_n;
    endproperty
    a_peq: assert property (p_peq) else $error("prop bad");

    // With the forced carry, ripple out high means A below B
    property p_cmp_lt;
        @(posedge clk) disable iff (sys_rst)
        clk_en && !mode_ctrl && sel_w == FBALU_SEL_SUB && !carry_input
        |=> carry_output == ($past(operand_a) < $past(operand_b));
    endproperty
    a_cmp_lt: assert property (p_cmp_lt) else $error("lt bad");

    // Cascade and equality outputs freeze with the rest
    property p_freeze;
        @(posedge clk) disable iff (sys_rst)
        !clk_en ##1 !sys_rst |-> $stable(group_prop_n)
            && $stable(group_gen_n) && $stable(equal_oe);
    endproperty
    a_freeze: assert property (p_freeze) else $error("not held");
endmodule

// >>> fbalu_peer.sv
// Far-side model: pull-up on the open-collector equality wire
module fbalu_peer (
    // Equality pin of one slice
    eq_level,
    eq_oe,
    // Resolved wire seen by the datapath
    eq_wire
);
    timeunit 1ns;
    timeprecision 1ns;
    input wire logic eq_level;
    input wire logic eq_oe;
    output logic eq_wire;
    // A released pin floats up, so wired slices AND their verdicts
    assign eq_wire = eq_oe ? eq_level : 1'b1;
endmodule

// >>> tb.sv
// Self-checking bench for the four-bit function generator
module tb import fbalu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, clk_en, sys_rst, m, ci, co, pn, gn, eo, oe, eqw;
    logic [3:0] a, b, s, f;
    int n_errors, checked;
    fbalu_top dut_u (.clk(clk), .clk_en(clk_en), .sys_rst(sys_rst),
        .operand_a(a), .operand_b(b), .func_select_bit0(s[0]),
        .func_select_bit1(s[1]), .func_select_bit2(s[2]),
        .func_select_bit3(s[3]), .mode_ctrl(m), .carry_input(ci),
        .result_bit0(f[0]), .result_bit1(f[1]), .result_bit2(f[2]),
        .result_bit3(f[3]), .carry_output(co), .group_prop_n(pn),
        .group_gen_n(gn), .equal_out(eo), .equal_oe(oe));
    fbalu_peer peer_u (.eq_level(eo), .eq_oe(oe), .eq_wire(eqw));
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Reference: {carry out_n, prop_n, gen_n, result}, carry in active low
    function automatic logic [6:0] model(input logic [3:0] xa, xb, xs,
        input logic xm, xc);
        logic [3:0] p, g, r;
        logic c;
        c = ~xc;
        for (int i = 0; i < 4; i++) begin
            p[i] = xa[i] | xb[i] & xs[0] | ~xb[i] & xs[1];
            g[i] = xa[i] & ~xb[i] & xs[2] | xa[i] & xb[i] & xs[3];
            r[i] = p[i] ^ g[i] ^ (xm | c);
            c = g[i] | p[i] & c;
        end
        return {~c, ~&p, ~(g[3] | p[3] & g[2] | &p[3:2] & g[1]
            | &p[3:1] & g[0]), r};
    endfunction
    // Inputs change just after an edge; outputs land one edge later
    task automatic drive(input logic [3:0] xa, xb, xs, input logic xm, xc);
        @(posedge clk);
        {a, b, s, m, ci} <= {xa, xb, xs, xm, xc};
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic check_rst();
        check(f, FBALU_RST_RESULT);
        check({co, pn, gn, oe}, {FBALU_RST_CARRY, FBALU_RST_PROP,
            FBALU_RST_GEN, FBALU_RST_EQ_OE});
    endtask
    // Every select, mode and carry against the reference
    task automatic t_sweep();
        logic [3:0] pa [3] = '{4'hA, 4'h3, 4'hF};
        logic [3:0] pb [3] = '{4'h6, 4'hC, 4'h1};
        logic [6:0] e;
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 64; k++) begin
                e = model(pa[p], pb[p], k[3:0], k[4], k[5]);
                drive(pa[p], pb[p], k[3:0], k[4], k[5]);
                check(f, e[3:0]);
                check({pn, gn}, e[5:4]);
                check(k[4] ? 4'h0 : {3'h0, co},
                    k[4] ? 4'h0 : {3'h0, e[6]});
                check({3'h0, eqw}, {3'h0, &e[3:0]});
            end
        end
    endtask
    // Carry in low is a live carry here, so a leak would show
    task automatic t_logic();
        drive(4'hC, 4'hA, 4'h6, 1'b1, 1'b0);
        check(f, 4'h6);
        drive(4'hC, 4'hA, 4'hB, 1'b1, 1'b0);
        check(f, 4'h8);
        drive(4'hC, 4'hA, 4'hE, 1'b1, 1'b0);
        check(f, 4'hE);
        drive(4'hC, 4'hA, 4'h4, 1'b1, 1'b0);
        check(f, 4'h7);
        drive(4'hC, 4'hA, 4'h1, 1'b1, 1'b0);
        check(f, 4'h1);
    endtask
    // Subtract without and with the forced carry, then doubling
    task automatic t_arith();
        drive(4'h9, 4'h3, FBALU_SEL_SUB, 1'b0, 1'b1);
        check(f, 4'h5);
        drive(4'h9, 4'h3, FBALU_SEL_SUB, 1'b0, 1'b0);
        check(f, 4'h6);
        drive(4'h5, 4'h0, FBALU_SEL_DBL, 1'b0, 1'b1);
        check(f, 4'hA);
        drive(4'h3, 4'h5, FBALU_SEL_ADD, 1'b0, 1'b1);
        check(f, 4'h8);
        check({3'h0, co}, 4'h1);
    endtask
    // Magnitude from the carry pair; equality on the wired pin
    task automatic t_cmp();
        logic [3:0] va [3] = '{4'h5, 4'h7, 4'h2};
        logic [3:0] vb [3] = '{4'h5, 4'h2, 4'h7};
        for (int i = 0; i < 3; i++) begin
            for (int c = 0; c < 2; c++) begin
                drive(va[i], vb[i], FBALU_SEL_SUB, 1'b0, c[0]);
                check({3'h0, co},
                    {3'h0, c[0] ? va[i] <= vb[i] : va[i] < vb[i]});
                check({3'h0, eqw}, {3'h0, c[0] & va[i] == vb[i]});
            end
        end
    endtask
    // Enable low must freeze the last answer
    task automatic t_hold();
        @(posedge clk);
        clk_en <= 1'b0;
        drive(4'hF, 4'hF, FBALU_SEL_PASS, 1'b1, 1'b1);
        check(f, 4'h8);
        @(posedge clk);
        clk_en <= 1'b1;
    endtask
    // Watchdog well beyond the few hundred cycles the run needs
    initial begin
        #(40 * 4000);
        n_errors++;
        print_verdict();
    end
    // Main sequence: reset, scenarios, mid-run reset
    initial begin
        {sys_rst, clk_en, a, b, s, m, ci} = {2'b11, 12'h000, 2'b01};
        n_errors = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check_rst();
        @(posedge clk);
        sys_rst <= 1'b0;
        t_sweep();
        t_logic();
        t_arith();
        t_hold();
        t_cmp();
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check_rst();
        @(posedge clk);
        sys_rst <= 1'b0;
        t_arith();
        print_verdict();
    end
endmodule
